// file: rtl/dma_pkg.sv
`default_nettype none
package dma_pkg;
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_THREADS = 9;
  localparam int NUM_PERIPH = 32;
  localparam int NUM_EVENTS = 8;
  localparam int AXI_DW = 64;
  localparam int AXI_AW = 32;
  localparam int MAX_RD_OUT = 8;
  localparam int MAX_WR_OUT = 8;
  localparam int QUEUE_DEPTH = 16;
  localparam int CACHE_LINES = 16;
  localparam int LINE_WORDS = 8;
  localparam int LINE_BYTES = 32;
  localparam int BUF_DEPTH = 16;
  localparam int SERIAL_TX_IF = 6;
  localparam int SERIAL_RX_IF = 7;
  localparam logic [1:0] REQ_SINGLE = 2'h0;
  localparam logic [1:0] REQ_BURST = 2'h1;
  localparam logic [1:0] REQ_FLUSH = 2'h2;
  localparam logic [1:0] REQ_RSVD = 2'h3;

  typedef enum logic [1:0] {
    width_8,
    width_16,
    width_32,
    width_64
  } elem_width_e;

  typedef struct packed {
    logic is_store;
    logic [3:0] thread;
    logic [AXI_AW-1:0] addr;
    elem_width_e width;
    logic [3:0] beats;
  } xfer_cmd_s;

  // Data plus seven Hamming check bits and overall parity
  typedef struct packed {
    logic [AXI_DW-1:0] data;
    logic [7:0] check;
  } ecc_word_s;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic last;
  } periph_req_s;
endpackage
`default_nettype wire

// file: rtl/staging_fifo.sv
`default_nettype none
module staging_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Maintenance
  input wire logic clear
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = wr_ptr == rd_ptr;
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full && !clear;
  assign out_valid = !empty && !clear;

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  assign out_data = mem[rd_ptr[AW-1:0]];
endmodule
`default_nettype wire

// file: rtl/dma_core.sv
`default_nettype none
module dma_core #(
  parameter int BUF_DEPTH = dma_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command ports: secure and non-secure, and status
  input wire logic sec_cmd_valid,
  output logic sec_cmd_ready,
  input wire logic [63:0] sec_cmd_data,
  input wire logic ns_cmd_valid,
  output logic ns_cmd_ready,
  input wire logic [63:0] ns_cmd_data,
  output logic [31:0] status,
  // ECC control
  input wire logic ecc_enable,
  input wire logic [1:0] ecc_inject,
  input wire logic ecc_init_start,
  output logic ecc_init_busy,
  output logic ecc_single_irq,
  output logic ecc_double_irq,
  // Interrupts
  output logic abort_irq,
  output logic [7:0] event_irq,
  // Peripheral requests
  input wire logic [31:0] periph_enable,
  input wire logic serial_select,
  input wire logic [1:0] serial_req,
  input wire logic [1:0] fabric_req,
  input wire dma_pkg::periph_req_s [31:0] periph_req,
  output logic [31:0] periph_req_ready,
  output logic [31:0] periph_ack_valid,
  output logic [1:0] periph_ack_type,
  input wire logic [31:0] periph_ack_ready,
  // Fetch path to master
  output logic fetch_valid,
  input wire logic fetch_ready,
  output logic [31:0] fetch_addr,
  input wire logic fetch_data_valid,
  input wire logic [63:0] fetch_data,
  input wire logic fetch_done,
  // Data command path to master
  output logic xfer_valid,
  input wire logic xfer_ready,
  output dma_pkg::xfer_cmd_s xfer_cmd,
  input wire logic rd_done,
  input wire logic wr_done,
  // Read data in and write data out
  input wire logic rdata_valid,
  output logic rdata_ready,
  input wire logic [63:0] rdata,
  output logic wdata_valid,
  input wire logic wdata_ready,
  output logic [63:0] wdata
);
  typedef enum logic [1:0] {fill_idle, fill_req, fill_data} fill_e;

  // Thread state
  logic [8:0] thread_run;
  logic [31:0] thread_pc [9];
  logic [3:0] cur;
  logic [3:0] next_cur;
  logic [31:0] cmd_word;
  logic cmd_take;
  logic cmd_sec;

  // Cache
  logic [31:0] line_data [dma_pkg::CACHE_LINES][dma_pkg::LINE_WORDS];
  logic [26:0] line_tag [dma_pkg::CACHE_LINES];
  logic [dma_pkg::CACHE_LINES-1:0] line_valid;
  fill_e fill;
  logic [3:0] fill_line;
  logic [26:0] fill_tag;
  logic [2:0] fill_word;
  logic hit;
  logic [31:0] pc;
  logic [3:0] idx;
  logic [31:0] instr_lo;
  logic spans;
  logic second_part;
  logic [31:0] hold_lo;

  // Queues and outstanding counts
  logic [4:0] rq_count;
  logic [4:0] wq_count;
  logic [3:0] rd_out;
  logic [3:0] wr_out;
  dma_pkg::xfer_cmd_s next_cmd;
  logic enq;
  logic issue;

  // Commands: word [63:32] is a target pc, [3:0] a thread, [4] start.
  // secure port wins
  assign cmd_take = sec_cmd_valid || ns_cmd_valid;
  assign cmd_sec = sec_cmd_valid;
  assign sec_cmd_ready = 1'b1;
  assign ns_cmd_ready = !sec_cmd_valid;
  assign cmd_word = cmd_sec ? sec_cmd_data[63:32] : ns_cmd_data[63:32];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thread_run <= '0;
      for (int i = 0; i < 9; i++) begin
        thread_pc[i] <= '0;
      end
    end else begin
      if (cmd_take) begin
        if ((cmd_sec ? sec_cmd_data[3:0] : ns_cmd_data[3:0]) < 4'h9) begin
          thread_pc[cmd_sec ? sec_cmd_data[3:0] : ns_cmd_data[3:0]] <= cmd_word;
          thread_run[cmd_sec ? sec_cmd_data[3:0] : ns_cmd_data[3:0]] <=
            cmd_sec ? sec_cmd_data[4] : ns_cmd_data[4];
        end
      end
      if (thread_run[cur] && hit && !enq_block() && !spans && !cmd_take) begin
        thread_pc[cur] <= thread_pc[cur] + 32'h4;
      end else if (thread_run[cur] && hit && spans && second_part && !cmd_take) begin
        thread_pc[cur] <= thread_pc[cur] + 32'h8;
      end
      if (thread_run[cur] && hit && instr_lo[31:28] == 4'h7 && !cmd_take) begin
        thread_run[cur] <= 1'b0;
      end
    end
  end

  function automatic logic enq_block();
    enq_block = instr_lo[31] && (instr_lo[30] ? wq_count == 5'h10 : rq_count == 5'h10);
  endfunction

  always_comb begin
    next_cur = cur;
    for (int k = 1; k <= 9; k++) begin
      if (thread_run[(int'(cur) + k) % 9] && next_cur == cur) begin
        next_cur = 4'((int'(cur) + k) % 9);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (!spans || second_part || !hit) begin
      cur <= next_cur;
    end
  end

  assign pc = thread_pc[cur];
  assign idx = pc[8:5];
  assign hit = line_valid[idx] && line_tag[idx] == pc[31:5] && !(fill != fill_idle && fill_line == idx);
  assign instr_lo = line_data[idx][pc[4:2]];
  assign spans = instr_lo[29] && pc[4:2] == 3'h7;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      second_part <= 1'b0;
      hold_lo <= '0;
    end else if (spans && hit && !second_part) begin
      second_part <= 1'b1;
      hold_lo <= instr_lo;
    end else if (second_part) begin
      second_part <= 1'b0;
    end
  end

  // demand fill only; one fill at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill <= fill_idle;
      fill_line <= '0;
      fill_tag <= '0;
      fill_word <= '0;
      line_valid <= '0;
    end else begin
      unique case (fill)
        fill_idle: begin
          if (thread_run[cur] && !hit) begin
            fill <= fill_req;
            fill_line <= idx;
            fill_tag <= pc[31:5];
            fill_word <= '0;
            line_valid[idx] <= 1'b0;
          end
        end
        fill_req: begin
          if (fetch_ready) begin
            fill <= fill_data;
          end
        end
        fill_data: begin
          if (fetch_data_valid) begin
            fill_word <= fill_word + 3'h2;
          end
          if (fetch_done) begin
            fill <= fill_idle;
            line_valid[fill_line] <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (fill == fill_data && fetch_data_valid) begin
      line_data[fill_line][fill_word] <= fetch_data[31:0];
      line_data[fill_line][fill_word + 3'h1] <= fetch_data[63:32];
      line_tag[fill_line] <= fill_tag;
    end
  end

  assign fetch_valid = fill == fill_req;
  assign fetch_addr = {fill_tag, 5'h00};

  // queue loads and stores; width field
  assign enq = thread_run[cur] && hit && instr_lo[31] && !spans && !enq_block();
  always_comb begin
    next_cmd.is_store = instr_lo[30];
    next_cmd.thread = cur;
    next_cmd.addr = {hold_lo[7:0], instr_lo[23:0]};
    next_cmd.width = dma_pkg::elem_width_e'(instr_lo[28:27]);
    next_cmd.beats = instr_lo[26:23];
  end

  logic q_in_ready;
  logic q_out_valid;
  dma_pkg::xfer_cmd_s q_out;
  staging_fifo #(.WIDTH($bits(dma_pkg::xfer_cmd_s)), .DEPTH(32)) cmd_queue (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(enq),
    .in_ready(q_in_ready),
    .in_data(next_cmd),
    .out_valid(q_out_valid),
    .out_ready(issue),
    .out_data(q_out),
    .clear(1'b0)
  );

  assign xfer_valid = q_out_valid &&
    (q_out.is_store ? wr_out < 4'h8 : rd_out < 4'h8);
  assign issue = xfer_valid && xfer_ready;
  assign xfer_cmd = q_out;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_count <= '0;
      wq_count <= '0;
      rd_out <= '0;
      wr_out <= '0;
    end else begin
      rq_count <= rq_count + 5'(enq && !next_cmd.is_store) - 5'(issue && !q_out.is_store);
      wq_count <= wq_count + 5'(enq && next_cmd.is_store) - 5'(issue && q_out.is_store);
      rd_out <= rd_out + 4'(issue && !q_out.is_store) - 4'(rd_done);
      wr_out <= wr_out + 4'(issue && q_out.is_store) - 4'(wr_done);
    end
  end

  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    c = '0;
    for (int b = 0; b < 64; b++) begin
      c[6:0] = c[6:0] ^ 7'(b + 1);
    end
    for (int b = 0; b < 64; b++) begin
      if (d[b]) begin
        c[6:0] = c[6:0] ^ 7'(b + 1);
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  dma_pkg::ecc_word_s buf_in;
  dma_pkg::ecc_word_s buf_out;
  logic buf_out_valid;
  logic [7:0] syn;
  logic par_err;
  logic [63:0] corrected;

  always_comb begin
    buf_in.data = rdata ^ {62'h0, ecc_inject[1], ecc_inject[0] | ecc_inject[1]};
    buf_in.check = ecc_gen(rdata);
  end

  staging_fifo #(.WIDTH($bits(dma_pkg::ecc_word_s)), .DEPTH(BUF_DEPTH)) staging_data_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rdata_valid && !ecc_init_busy),
    .in_ready(rdata_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(wdata_ready && !ecc_init_busy),
    .out_data(buf_out),
    .clear(ecc_init_busy)
  );

  assign syn = ecc_gen(buf_out.data) ^ buf_out.check;
  // Overall parity of the stored word: odd means one flipped bit
  assign par_err = ^{buf_out.data, buf_out.check};
  always_comb begin
    corrected = buf_out.data;
    for (int b = 0; b < 64; b++) begin
      if (ecc_enable && par_err && syn[6:0] == 7'(b + 1)) begin
        corrected[b] = !corrected[b];
      end
    end
  end

  assign wdata_valid = buf_out_valid && !ecc_init_busy;
  assign wdata = corrected;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ecc_single_irq <= 1'b0;
      ecc_double_irq <= 1'b0;
    end else begin
      ecc_single_irq <= ecc_enable && wdata_valid && wdata_ready && par_err;
      ecc_double_irq <= ecc_enable && wdata_valid && wdata_ready && !par_err && syn[6:0] != 7'h00;
    end
  end

  logic [4:0] init_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= '0;
    end else if (init_cnt != 5'h00) begin
      init_cnt <= init_cnt - 5'h01;
    end else if (ecc_init_start) begin
      init_cnt <= 5'(BUF_DEPTH);
    end
  end
  assign ecc_init_busy = init_cnt != 5'h00;

  logic [31:0] req_valid;
  always_comb begin
    for (int p = 0; p < 32; p++) begin
      req_valid[p] = periph_enable[p] && periph_req[p].valid &&
        periph_req[p].kind != dma_pkg::REQ_RSVD;
    end
    req_valid[dma_pkg::SERIAL_TX_IF] = periph_enable[dma_pkg::SERIAL_TX_IF] &&
      (serial_select ? serial_req[0] : fabric_req[0]);
    req_valid[dma_pkg::SERIAL_RX_IF] = periph_enable[dma_pkg::SERIAL_RX_IF] &&
      (serial_select ? serial_req[1] : fabric_req[1]);
  end

  logic [31:0] ack_pend;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_pend <= '0;
      periph_ack_type <= dma_pkg::REQ_SINGLE;
    end else begin
      for (int p = 0; p < 32; p++) begin
        if (req_valid[p] && !ack_pend[p]) begin
          ack_pend[p] <= 1'b1;
          periph_ack_type <= periph_req[p].kind == dma_pkg::REQ_BURST ?
            dma_pkg::REQ_BURST : dma_pkg::REQ_SINGLE;
        end else if (ack_pend[p] && periph_ack_ready[p]) begin
          ack_pend[p] <= 1'b0;
        end
      end
    end
  end
  assign periph_req_ready = req_valid & ~ack_pend;
  assign periph_ack_valid = ack_pend;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_irq <= 1'b0;
      event_irq <= '0;
    end else begin
      abort_irq <= thread_run[cur] && hit && instr_lo[31:28] == 4'h7;
      event_irq <= (thread_run[cur] && hit && instr_lo[31:28] == 4'h6) ?
        8'h01 << instr_lo[2:0] : 8'h00;
    end
  end

  assign status = {ecc_init_busy, fill != fill_idle, 5'h00, rq_count, wq_count,
    rd_out[2:0], wr_out[2:0], thread_run};
endmodule
`default_nettype wire

// file: tb/dma_core_chk.sv
`default_nettype none
module dma_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands, ECC and abort
  input wire logic sec_cmd_valid,
  input wire logic ns_cmd_ready,
  input wire logic ecc_enable,
  input wire logic wdata_valid,
  input wire logic wdata_ready,
  input wire logic ecc_init_start,
  input wire logic ecc_init_busy,
  input wire logic ecc_single_irq,
  input wire logic ecc_double_irq,
  input wire logic abort_irq,
  // Peripheral acknowledge
  input wire logic [31:0] periph_ack_valid,
  input wire logic [1:0] periph_ack_type,
  input wire logic [31:0] periph_ack_ready,
  // Master side
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire logic [31:0] fetch_addr,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire dma_pkg::xfer_cmd_s xfer_cmd,
  input wire logic rd_done,
  input wire logic wr_done,
  input wire logic rdata_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int rd_out;
  int wr_out;
  logic [31:0] ack_wait;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reads and writes in flight, and acks left waiting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_out <= 0;
      wr_out <= 0;
      ack_wait <= 32'h0;
    end else begin
      rd_out <= rd_out + ((xfer_valid && xfer_ready && !xfer_cmd.is_store) ? 1 : 0) - (rd_done ? 1 : 0);
      wr_out <= wr_out + ((xfer_valid && xfer_ready && xfer_cmd.is_store) ? 1 : 0) - (wr_done ? 1 : 0);
      ack_wait <= periph_ack_valid & ~periph_ack_ready;
    end
  end
  a_ns_refused: assert property (sec_cmd_valid |-> !ns_cmd_ready)
    else $error("non-secure command taken beside secure");
  a_init_runs: assert property (ecc_init_start && !ecc_init_busy |=> ecc_init_busy [*8])
    else $error("buffer init ended early");
  a_init_refuse: assert property (ecc_init_busy |-> !rdata_ready)
    else $error("data taken during init");
  a_single_pulse: assert property (ecc_single_irq |-> $past(ecc_enable && wdata_valid && wdata_ready))
    else $error("single error irq without a drained word");
  a_double_pulse: assert property (ecc_double_irq |-> $past(ecc_enable && wdata_valid && wdata_ready))
    else $error("double error irq without a drained word");
  a_abort_pulse: assert property (abort_irq |=> !abort_irq)
    else $error("abort irq longer than a cycle");
  a_ack_hold: assert property (|ack_wait |-> (ack_wait & ~periph_ack_valid) == 32'h0
    && $stable(periph_ack_type))
    else $error("ack dropped or changed before ready");
  a_ack_type: assert property (|periph_ack_valid |-> periph_ack_type != dma_pkg::REQ_RSVD)
    else $error("reserved ack type");
  a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr))
    else $error("fill request dropped before ready");
  a_xfer_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_cmd))
    else $error("transfer command changed before ready");
  a_rd_limit: assert property (rd_out <= dma_pkg::MAX_RD_OUT)
    else $error("too many reads outstanding");
  a_wr_limit: assert property (wr_out <= dma_pkg::MAX_WR_OUT)
    else $error("too many writes outstanding");
endmodule
`default_nettype wire

// file: tb/far_side_model.sv
`default_nettype none
module far_side_model (
  // Clock, reset and bench controls
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] insn,
  input wire logic stall,
  // Line fills
  input wire logic fetch_valid,
  output logic fetch_ready,
  output logic fetch_data_valid,
  output logic [63:0] fetch_data,
  output logic fetch_done,
  // Transfer commands
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire dma_pkg::xfer_cmd_s xfer_cmd,
  output logic rd_done,
  output logic wr_done,
  // Data beats
  output logic rdata_valid,
  input wire logic rdata_ready,
  output logic [63:0] rdata,
  input wire logic wdata_valid,
  output logic wdata_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] beat;
  logic [4:0] rd_pend;
  logic [4:0] wr_pend;
  logic give_rd;
  logic give_wr;
  assign xfer_ready = 1'h1;
  assign wdata_ready = !stall;
  assign give_rd = rdata_valid && rdata_ready;
  assign give_wr = wdata_valid && wdata_ready && wr_pend != 5'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ready <= 1'h0;
      beat <= 3'h0;
      fetch_data_valid <= 1'h0;
      fetch_done <= 1'h0;
      fetch_data <= 64'h0;
    end else begin
      fetch_ready <= fetch_valid && !fetch_ready && beat == 3'h0;
      if (fetch_ready) beat <= 3'h1;
      else if (beat != 3'h0) beat <= (beat == 3'h5) ? 3'h0 : beat + 3'h1;
      fetch_data_valid <= beat != 3'h0 && beat != 3'h5;
      fetch_done <= beat == 3'h5;
      fetch_data <= (beat != 3'h0 && beat != 3'h5) ? insn : ~fetch_data;
    end
  end
  // one beat per load, held until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_valid <= 1'h0;
      rdata <= 64'h0;
      rd_pend <= 5'h0;
      rd_done <= 1'h0;
      wr_pend <= 5'h0;
      wr_done <= 1'h0;
    end else begin
      if (give_rd) rdata_valid <= 1'h0;
      else if (rd_pend != 5'h0) rdata_valid <= 1'h1;
      if (!rdata_valid || rdata_ready) rdata <= rdata + 64'h0101;
      rd_pend <= rd_pend + 5'(xfer_valid && !xfer_cmd.is_store) - 5'(give_rd);
      rd_done <= give_rd;
      wr_pend <= wr_pend + 5'(xfer_valid && xfer_cmd.is_store) - 5'(give_wr);
      wr_done <= give_wr;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sec_cmd_valid, ns_cmd_valid, sec_cmd_ready, ns_cmd_ready, serial_select, stall;
  logic ecc_enable, ecc_init_start, ecc_init_busy, ecc_single_irq, ecc_double_irq, abort_irq;
  logic fetch_valid, fetch_ready, fetch_data_valid, fetch_done, xfer_valid, xfer_ready;
  logic rd_done, wr_done, rdata_valid, rdata_ready, wdata_valid, wdata_ready;
  logic [63:0] sec_cmd_data, ns_cmd_data, fetch_data, rdata, wdata, insn;
  logic [31:0] status, fetch_addr, periph_enable, periph_req_ready;
  logic [31:0] periph_ack_valid, periph_ack_ready;
  logic [1:0] ecc_inject, serial_req, fabric_req, periph_ack_type;
  logic [7:0] event_irq;
  dma_pkg::periph_req_s [31:0] periph_req;
  dma_pkg::xfer_cmd_s xfer_cmd;
  int error_cnt = 0;
  int checks = 0;
  int n;
  int k;
  dma_core dut (.*);
  far_side_model partner (.*);
  always #2 clk = ~clk;
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task expect_eq(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  // A wait that ran out ends the run
  task expect_seen(input logic ok, input string what);
    expect_eq({63'h0, ok}, 64'h1, what);
    if (ok !== 1'h1) end_of_test;
  endtask
  task run_thread(input logic sec, input logic [3:0] thr, input logic [31:0] pc);
    @(negedge clk);
    sec_cmd_data = {pc, 27'h0, 1'h1, thr};
    ns_cmd_data = {pc, 27'h0, 1'h1, thr};
    sec_cmd_valid = sec;
    ns_cmd_valid = !sec;
    for (n = 0; n < 50 && (sec ? sec_cmd_ready : ns_cmd_ready) !== 1'h1; n++) @(negedge clk);
    expect_seen(n < 50, "command wait");
    @(negedge clk);
    sec_cmd_valid = 1'h0;
    ns_cmd_valid = 1'h0;
  endtask
  task stop_all;
    @(negedge clk);
    sec_cmd_valid = 1'h1;
    for (k = 0; k < 9; k++) begin
      sec_cmd_data = {32'h0, 27'h0, 1'h0, 4'(k)};
      @(negedge clk);
    end
    sec_cmd_valid = 1'h0;
  endtask
  task t_reset;
    expect_eq({xfer_valid, abort_irq, event_irq, status}, 64'h0, "idle outputs");
    expect_eq(fetch_valid, 1'h0, "fill before start");
    $display("t_reset done");
  endtask
  task t_init;
    @(negedge clk);
    ecc_init_start = 1'h1;
    @(negedge clk);
    ecc_init_start = 1'h0;
    for (n = 0; n < 100 && ecc_init_busy === 1'h1; n++) @(negedge clk);
    expect_eq(n, 16, "init length");
    $display("t_init done");
  endtask
  task t_fetch;
    insn = {32'hC000_0000, 32'h8000_0000};
    run_thread(1'h1, 4'h0, 32'h0000_0100);
    for (n = 0; n < 20 && fetch_valid !== 1'h1; n++) @(negedge clk);
    expect_seen(fetch_valid, "miss fill");
    expect_eq(fetch_addr, 32'h0000_0100, "fill address");
    $display("t_fetch done");
  endtask
  task t_queue;
    for (n = 0; n < 200 && xfer_valid !== 1'h1; n++) @(negedge clk);
    expect_seen(xfer_valid, "load queued");
    expect_eq({xfer_cmd.is_store, xfer_cmd.thread}, 5'h00, "load first");
    for (n = 0; n < 200 && !(xfer_valid && xfer_cmd.is_store); n++) @(negedge clk);
    expect_seen(n < 200, "store queued");
    $display("t_queue done");
  endtask
  task t_ports;
    @(negedge clk);
    sec_cmd_data = {32'h0000_0300, 27'h0, 1'h1, 4'h8};
    ns_cmd_data = {32'h0000_0200, 27'h0, 1'h1, 4'h5};
    sec_cmd_valid = 1'h1;
    ns_cmd_valid = 1'h1;
    #1;
    expect_eq(ns_cmd_ready, 1'h0, "non-secure beside secure");
    @(negedge clk);
    sec_cmd_valid = 1'h0;
    for (n = 0; n < 50 && ns_cmd_ready !== 1'h1; n++) @(negedge clk);
    @(negedge clk);
    ns_cmd_valid = 1'h0;
    for (n = 0; n < 400 && !(fetch_valid && fetch_addr == 32'h200); n++) @(negedge clk);
    expect_seen(n < 400, "non-secure thread runs");
    $display("t_ports done");
  endtask
  task t_fill;
    stop_all;
    insn = {32'h8000_0000, 32'h8000_0000};
    run_thread(1'h1, 4'h1, 32'h0008_0000);
    stall = 1'h1;
    for (n = 0; n < 1000 && !(rdata_valid && !rdata_ready); n++) @(negedge clk);
    expect_seen(n < 1000, "full buffer refuses");
    stall = 1'h0;
    for (n = 0; n < 1000 && rdata_ready !== 1'h1; n++) @(negedge clk);
    expect_seen(rdata_ready, "drained buffer takes");
    $display("t_fill done");
  endtask
  task t_ecc;
    ecc_enable = 1'h1;
    ecc_inject = 2'h1;
    run_thread(1'h1, 4'h4, 32'h0000_0600);
    for (n = 0; n < 1000 && ecc_single_irq !== 1'h1; n++) @(negedge clk);
    expect_seen(ecc_single_irq, "single error");
    ecc_inject = 2'h2;
    for (n = 0; n < 1000 && ecc_double_irq !== 1'h1; n++) @(negedge clk);
    expect_seen(ecc_double_irq, "double error");
    ecc_inject = 2'h0;
    $display("t_ecc done");
  endtask
  task t_irq(input logic [31:0] op, input logic [3:0] thr, input logic [31:0] pc);
    stop_all;
    insn = {op, op};
    run_thread(1'h1, thr, pc);
    for (n = 0; n < 400 && (abort_irq || |event_irq) !== 1'h1; n++) @(negedge clk);
    expect_eq({abort_irq, event_irq}, {op[28], op[28] ? 8'h00 : 8'h01 << op[2:0]}, "irq line");
    $display("t_irq done");
  endtask
  task t_periph;
    @(negedge clk);
    periph_enable = 32'h0000_00C8;
    periph_ack_ready = 32'hFFFF_FFFF;
    serial_select = 1'h1;
    serial_req = 2'h2;
    fabric_req = 2'h1;
    #0.5;
    expect_eq(periph_req_ready[7:6], 2'h2, "serial owns shared pair");
    serial_select = 1'h0;
    #0.5;
    expect_eq(periph_req_ready[7:6], 2'h1, "fabric owns shared pair");
    {serial_req, fabric_req} = 4'h0;
    for (k = 0; k < 3; k++) begin
      @(negedge clk);
      periph_req[3] = '{1'h1, 2'(k), k == 2};
      for (n = 0; n < 200 && periph_req_ready[3] !== 1'h1; n++) @(negedge clk);
      expect_seen(periph_req_ready[3], "request taken");
      @(negedge clk);
      periph_req[3] = '{1'h0, 2'h0, 1'h0};
      expect_eq({periph_ack_valid[3], periph_ack_type},
        {1'h1, k == 1 ? dma_pkg::REQ_BURST : dma_pkg::REQ_SINGLE}, "ack type");
    end
    repeat (20) @(negedge clk);
    $display("t_periph done");
  endtask
  initial begin
    {sec_cmd_valid, ns_cmd_valid, ecc_enable, ecc_init_start, serial_select, stall} = 6'h0;
    sec_cmd_data = 64'h0;
    ns_cmd_data = 64'h0;
    insn = 64'h0;
    {ecc_inject, serial_req, fabric_req} = 6'h0;
    periph_enable = 32'h0;
    periph_ack_ready = 32'h0;
    periph_req = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    t_reset;
    t_init;
    t_fetch;
    t_queue;
    t_ports;
    t_fill;
    t_ecc;
    t_irq(32'h7000_0000, 4'h2, 32'h0010_0000);
    t_irq(32'h6000_0003, 4'h3, 32'h0020_0000);
    t_periph;
    end_of_test;
  end
endmodule
bind dma_core dma_core_chk u_chk (.*);
`default_nettype wire
